// ---- bench/rut_event_src.sv ----
`timescale 1ns/10ps
module rut_event_src (
    input  wire logic clk_i,
    output logic      event_o,
    output logic      dir_o,
    output logic      sub_clk_o
);
    int sub_cnt = 0;

    initial begin
        event_o   = 1'b0;
        dir_o     = 1'b0;
        sub_clk_o = 1'b0;
    end

    // ------------------------------------------------------------
    // free-running subclock, period 20 system clocks
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        sub_cnt <= (sub_cnt == 9) ? 0 : sub_cnt + 1;
        if (sub_cnt == 9) begin
            sub_clk_o <= ~sub_clk_o;
        end
    end

    // ------------------------------------------------------------
    // event pulses: wide enough to survive the pin synchroniser
    // ------------------------------------------------------------
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk_i);
            event_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            event_o <= 1'b0;
            repeat (5) @(posedge clk_i);
        end
    endtask

    task automatic level(input logic v);
        @(posedge clk_i);
        event_o <= v;
        repeat (8) @(posedge clk_i);
    endtask

    // direction settles before the next event edge arrives
    task automatic set_dir(input logic v);
        @(posedge clk_i);
        dir_o <= v;
        repeat (6) @(posedge clk_i);
    endtask
endmodule

// ---- bench/test_reloadable_updown_timer.sv ----
`timescale 1ns/10ps
module test_reloadable_updown_timer;
    import rut_pkg::*;

    logic        clk_i = 1'b0;
    logic        rst_i;
    logic [3:0]  adr;
    logic        rd_q;
    logic        wr_q;
    logic [31:0] wdat;
    logic [3:0]  ben;
    logic [31:0] rdat;
    logic        wreq;
    logic        sub_clk;
    logic        ev_pin;
    logic        dir_pin;
    logic        irq;
    int          err_total = 0;
    int          tests_run = 0;

    always #4 clk_i = ~clk_i;

    rut_event_src src (.clk_i(clk_i), .event_o(ev_pin), .dir_o(dir_pin),
                       .sub_clk_o(sub_clk));

    rut_timer dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
        .avs_read_i(rd_q), .avs_write_i(wr_q), .avs_writedata_i(wdat),
        .avs_byteenable_i(ben), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .sub_clk_i(sub_clk),
        .event_count_pin_i(ev_pin), .direction_pin_i(dir_pin), .irq_o(irq));

    // ------------------------------------------------------------
    // checking and bus helpers
    // ------------------------------------------------------------
    task automatic check_eq(input string nm, input logic [7:0] exp,
                            input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic check_rng(input string nm, input int lo, input int hi,
                             input logic [7:0] got);
        tests_run++;
        if ($isunknown(got) || got < lo || got > hi) begin
            err_total++;
            $display("wrong value %s expected %0d..%0d seen %h", nm, lo, hi,
                     got);
        end
    endtask

    // the request stands until waitrequest is seen low at a rising edge
    task automatic bus(input logic r, input logic [3:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        rd_q <= r;
        wr_q <= !r;
        adr  <= a;
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        if (n >= 40) begin
            err_total++;
            $display("wrong value waitrequest expected 0 seen %b", wreq);
        end
        q = rdat[7:0];
        rd_q <= 1'b0;
        wr_q <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b0, a, d, q);
    endtask

    task automatic chk_rd(input string nm, input logic [3:0] a,
                          input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b1, a, 8'h00, q);
        check_eq(nm, exp, q);
    endtask

    task automatic chk_irq(input logic exp);
        check_eq("irq", {7'h00, exp}, {7'h00, irq});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        chk_rd("mode", RUT_ADDR_MODE, 8'h18);
        chk_rd("count", RUT_ADDR_COUNT, 8'h00);
        chk_rd("status", RUT_ADDR_STATUS, 8'h00);
        chk_irq(1'b0);
        wr(RUT_ADDR_MODE, 8'hFF);
        chk_rd("mode", RUT_ADDR_MODE, 8'hDF);
        wr(RUT_ADDR_MODE, 8'h00);
        chk_rd("mode", RUT_ADDR_MODE, 8'h18);
        @(posedge clk_i);
        ben <= 4'h0;
        wr(RUT_ADDR_MODE, 8'hC7);
        @(posedge clk_i);
        ben <= 4'hF;
        chk_rd("mode", RUT_ADDR_MODE, 8'h18);
        wr(4'h2, 8'h55);
        chk_rd("unmapped", 4'h2, 8'h00);
        wr(RUT_ADDR_MODE, 8'h80);
        wr(RUT_ADDR_COUNT, 8'h5A);
        chk_rd("count", RUT_ADDR_COUNT, 8'h5A);
        wr(RUT_ADDR_MODE, 8'h00);
        wr(RUT_ADDR_COUNT, 8'h33);
        chk_rd("count", RUT_ADDR_COUNT, 8'h5A);
        $display("test regs done");
    endtask

    // event pin function on and its own interrupt switched on and off, system side
    task automatic t_event();
        wr(RUT_ADDR_MODE, 8'h87);
        chk_rd("mode", RUT_ADDR_MODE, 8'h9F);
        wr(RUT_ADDR_CTRL, 8'h00);
        wr(RUT_ADDR_COUNT, 8'hFD);
        src.pulse(2);
        chk_rd("count", RUT_ADDR_COUNT, 8'hFF);
        chk_rd("status", RUT_ADDR_STATUS, 8'h00);
        src.pulse(1);
        chk_rd("count", RUT_ADDR_COUNT, 8'hFD);
        chk_rd("status", RUT_ADDR_STATUS, 8'h01);
        chk_irq(1'b0);
        wr(RUT_ADDR_STATUS, 8'h02);
        chk_irq(1'b1);
        wr(RUT_ADDR_STATUS, 8'h03);
        chk_rd("status", RUT_ADDR_STATUS, 8'h02);
        chk_irq(1'b0);
        wr(RUT_ADDR_COUNT, 8'h00);
        src.pulse(255);
        chk_rd("count", RUT_ADDR_COUNT, 8'hFF);
        chk_rd("status", RUT_ADDR_STATUS, 8'h02);
        src.pulse(1);
        chk_rd("count", RUT_ADDR_COUNT, 8'h00);
        chk_irq(1'b1);
        wr(RUT_ADDR_COUNT, 8'hFF);
        wr(RUT_ADDR_STATUS, 8'h01);
        src.pulse(1);
        chk_rd("count", RUT_ADDR_COUNT, 8'hFF);
        chk_rd("status", RUT_ADDR_STATUS, 8'h01);
        wr(RUT_ADDR_STATUS, 8'h01);
        $display("test event done");
    endtask

    task automatic t_edge_down();
        wr(RUT_ADDR_CTRL, 8'h02);
        wr(RUT_ADDR_COUNT, 8'h40);
        src.level(1'b1);
        chk_rd("count", RUT_ADDR_COUNT, 8'h40);
        src.level(1'b0);
        chk_rd("count", RUT_ADDR_COUNT, 8'h41);
        wr(RUT_ADDR_CTRL, 8'h01);
        wr(RUT_ADDR_COUNT, 8'h01);
        src.pulse(2);
        chk_rd("count", RUT_ADDR_COUNT, 8'h01);
        chk_rd("status", RUT_ADDR_STATUS, 8'h01);
        wr(RUT_ADDR_STATUS, 8'h01);
        $display("test edge_down done");
    endtask

    // direction pin function switched on and off, system side
    task automatic t_hwdir();
        wr(RUT_ADDR_COUNT, 8'h10);
        wr(RUT_ADDR_MODE, 8'hC7);
        src.set_dir(1'b0);
        src.pulse(1);
        chk_rd("count", RUT_ADDR_COUNT, 8'h11);
        src.set_dir(1'b1);
        src.pulse(1);
        chk_rd("count", RUT_ADDR_COUNT, 8'h10);
        wr(RUT_ADDR_MODE, 8'h07);
        src.set_dir(1'b0);
        src.pulse(1);
        chk_rd("count", RUT_ADDR_COUNT, 8'h0F);
        wr(RUT_ADDR_MODE, 8'h87);
        wr(RUT_ADDR_COUNT, 8'h00);
        wr(RUT_ADDR_MODE, 8'h47);
        wr(RUT_ADDR_COUNT, 8'h80);
        chk_rd("count", RUT_ADDR_COUNT, 8'h00);
        src.set_dir(1'b1);
        src.pulse(1);
        chk_rd("count", RUT_ADDR_COUNT, 8'hFF);
        chk_rd("status", RUT_ADDR_STATUS, 8'h01);
        src.set_dir(1'b0);
        src.pulse(1);
        chk_rd("count", RUT_ADDR_COUNT, 8'h00);
        wr(RUT_ADDR_STATUS, 8'h01);
        $display("test hwdir done");
    endtask

    // reset in mid-run must bring count, mode and status back
    task automatic t_reset();
        wr(RUT_ADDR_MODE, 8'h87);
        wr(RUT_ADDR_COUNT, 8'h5A);
        wr(RUT_ADDR_STATUS, 8'h02);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_rd("count", RUT_ADDR_COUNT, 8'h00);
        chk_rd("mode", RUT_ADDR_MODE, 8'h18);
        chk_rd("status", RUT_ADDR_STATUS, 8'h00);
        $display("test reset done");
    endtask

    // subclock tick is 4 subclock periods of 20 clocks each
    task automatic t_presc();
        logic [7:0] code[7] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h00, 8'h03,
                                8'h05};
        int         div[7]  = '{2048, 512, 16, 80, 64, 64, 64};
        int         lo[7]   = '{3, 3, 3, 3, 0, 0, 0};
        int         hi[7]   = '{5, 5, 5, 5, 0, 0, 0};
        logic [7:0] q;
        wr(RUT_ADDR_CTRL, 8'h00);
        for (int i = 0; i < 7; i++) begin
            wr(RUT_ADDR_MODE, 8'h80);
            wr(RUT_ADDR_COUNT, 8'h00);
            wr(RUT_ADDR_MODE, 8'h80 | code[i]);
            repeat (4 * div[i]) @(posedge clk_i);
            wr(RUT_ADDR_MODE, 8'h80);
            bus(1'b1, RUT_ADDR_COUNT, 8'h00, q);
            check_rng("prescaled count", lo[i], hi[i], q);
        end
        $display("test presc done");
    endtask

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        err_total++;
        end_of_test();
    end

    initial begin
        rst_i = 1'b1;
        adr   = 4'h0;
        rd_q  = 1'b0;
        wr_q  = 1'b0;
        wdat  = 32'h0;
        ben   = 4'hF;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_event();
        t_edge_down();
        t_hwdir();
        t_reset();
        t_presc();
        end_of_test();
    end
endmodule

// ---- src/rut_pkg.sv ----
package rut_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [3:0] RUT_ADDR_MODE   = 4'h0;
    localparam logic [3:0] RUT_ADDR_COUNT  = 4'h4;
    localparam logic [3:0] RUT_ADDR_CTRL   = 4'h8;
    localparam logic [3:0] RUT_ADDR_STATUS = 4'hC;
    localparam logic [3:0] RUT_ADDR_MASK   = 4'hC + 4'h0;

    // ------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------
    localparam int         RUT_MODE_RELOAD_BIT = 7;
    localparam int         RUT_MODE_HWDIR_BIT  = 6;
    localparam logic [7:0] RUT_MODE_RSVD_MASK  = 8'h18;
    localparam logic [7:0] RUT_MODE_WR_MASK    = 8'hC7;
    localparam logic [7:0] RUT_MODE_RESET      = 8'h00;
    localparam logic [7:0] RUT_COUNT_RESET     = 8'h00;
    localparam logic [7:0] RUT_COUNT_MAX       = 8'hFF;

    // ------------------------------------------------------------
    // control register fields (software direction, event edge)
    // ------------------------------------------------------------
    localparam int RUT_CTRL_SWDOWN_BIT = 0;
    localparam int RUT_CTRL_EDGE_BIT   = 1;

    // ------------------------------------------------------------
    // clock selection codes and prescaler taps
    // ------------------------------------------------------------
    localparam logic [2:0] RUT_CS_DIV2048 = 3'h1;
    localparam logic [2:0] RUT_CS_DIV512  = 3'h2;
    localparam logic [2:0] RUT_CS_DIV16   = 3'h4;
    localparam logic [2:0] RUT_CS_SUB4    = 3'h6;
    localparam logic [2:0] RUT_CS_EVENT   = 3'h7;
    localparam int         RUT_PRESC_W    = 11;
    localparam int         RUT_SUB_DIV    = 4;

    // ------------------------------------------------------------
    // bus
    // ------------------------------------------------------------
    localparam int RUT_DATA_W = 32;
    localparam int RUT_ADDR_W = 4;

    typedef struct packed {
        logic                  read;
        logic                  write;
        logic [RUT_ADDR_W-1:0] address;
        logic [RUT_DATA_W-1:0] writedata;
        logic [3:0]            byteenable;
    } rut_bus_req_t;

endpackage

// ---- src/rut_presc.sv ----
`timescale 1ns/10ps
module rut_presc
    import rut_pkg::*;
#(
    parameter int PRESC_W = RUT_PRESC_W
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       sub_clk_i,
    output logic            tick2048_o,
    output logic            tick512_o,
    output logic            tick16_o,
    output logic            tick_sub_o
);
    logic [PRESC_W-1:0] cnt_reg;
    logic [1:0]         sub_cnt_reg;
    logic               sub_prev_reg;
    logic               sub_rise;

    initial begin
        if (PRESC_W < 11) $error("prescaler too narrow for divide by 2048");
    end

    // each tick is a one-cycle pulse at the divided rate
    assign tick2048_o = (cnt_reg[10:0] == 11'h7FF);
    assign tick512_o  = (cnt_reg[8:0] == 9'h1FF);
    assign tick16_o   = (cnt_reg[3:0] == 4'hF);
    assign sub_rise   = sub_clk_i & ~sub_prev_reg;
    assign tick_sub_o = sub_rise & (sub_cnt_reg == 2'(RUT_SUB_DIV - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg      <= '0;
            sub_cnt_reg  <= 2'h0;
            sub_prev_reg <= 1'b0;
        end else begin
            cnt_reg      <= cnt_reg + 1'b1;
            sub_prev_reg <= sub_clk_i;
            if (sub_rise) begin
                sub_cnt_reg <= sub_cnt_reg + 2'h1;
            end
        end
    end
endmodule

// ---- src/rut_sync.sv ----
`timescale 1ns/10ps
module rut_sync
    import rut_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_reg;
    logic sync_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule

// ---- src/rut_timer.sv ----
`timescale 1ns/10ps
module rut_timer
    import rut_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        sub_clk_i,
    input  wire logic        event_count_pin_i,
    input  wire logic        direction_pin_i,
    output logic             irq_o
);
    // ------------------------------------------------------------
    // registers and wires
    // ------------------------------------------------------------
    rut_bus_req_t req;
    logic [7:0]   timer_mode_select_reg;
    logic [7:0]   timer_count_value_reg;
    logic [7:0]   timer_count_value_next;
    logic [7:0]   timer_reload_value_reg;
    logic [1:0]   ctrl_reg;
    logic         timer_irq_flag_reg;
    logic         irq_mask_reg;
    logic         ack_reg;
    logic [31:0]  rdata_reg;
    logic         event_sync;
    logic         dir_sync;
    logic         event_prev_reg;
    logic         tick2048;
    logic         tick512;
    logic         tick16;
    logic         tick_sub;
    logic         event_tick;
    logic         step;
    logic         count_down;
    logic         at_limit;
    logic         wrap;
    logic         auto_reload;
    logic [2:0]   clock_select;
    logic         access;
    logic         wr_stb;
    logic         wr_mode;
    logic         wr_reload;
    logic         wr_ctrl;
    logic         wr_status;
    logic [7:0]   mode_view;
    logic [31:0]  rdata_next;

    assign req = '{read: avs_read_i, write: avs_write_i,
                   address: avs_address_i, writedata: avs_writedata_i,
                   byteenable: avs_byteenable_i};

    // ------------------------------------------------------------
    // pin synchronisers and prescaler
    // ------------------------------------------------------------
    rut_sync u_sync_event (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (event_count_pin_i),
        .sync_o  (event_sync)
    );

    rut_sync u_sync_dir (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (direction_pin_i),
        .sync_o  (dir_sync)
    );

    rut_presc u_presc (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .sub_clk_i  (sub_clk_i),
        .tick2048_o (tick2048),
        .tick512_o  (tick512),
        .tick16_o   (tick16),
        .tick_sub_o (tick_sub)
    );

    // ------------------------------------------------------------
    // input clock selection and direction
    // ------------------------------------------------------------
    assign clock_select = timer_mode_select_reg[2:0];
    assign auto_reload  = timer_mode_select_reg[RUT_MODE_RELOAD_BIT];

    // edge detect on synchronised sample only
    assign event_tick = ctrl_reg[RUT_CTRL_EDGE_BIT]
                      ? (~event_sync & event_prev_reg)
                      : (event_sync & ~event_prev_reg);

    // unlisted codes (000, 011, 101) leave the counter stopped
    assign step = (clock_select == RUT_CS_DIV2048) ? tick2048 :
                  (clock_select == RUT_CS_DIV512)  ? tick512  :
                  (clock_select == RUT_CS_DIV16)   ? tick16   :
                  (clock_select == RUT_CS_SUB4)    ? tick_sub :
                  (clock_select == RUT_CS_EVENT)   ? event_tick :
                  1'b0;

    assign count_down = timer_mode_select_reg[RUT_MODE_HWDIR_BIT]
                      ? dir_sync
                      : ctrl_reg[RUT_CTRL_SWDOWN_BIT];

    assign at_limit = count_down ? (timer_count_value_reg == 8'h00)
                                 : (timer_count_value_reg == RUT_COUNT_MAX);
    assign wrap     = step & at_limit;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign access    = req.read | req.write;
    assign wr_stb    = req.write & ~ack_reg & req.byteenable[0];
    assign wr_mode   = wr_stb & (req.address == RUT_ADDR_MODE);
    assign wr_reload = wr_stb & (req.address == RUT_ADDR_COUNT);
    assign wr_ctrl   = wr_stb & (req.address == RUT_ADDR_CTRL);
    // the mask lives in the status word at bit 1, so no separate strobe
    assign wr_status = wr_stb & (req.address == RUT_ADDR_STATUS);

    assign mode_view = timer_mode_select_reg | RUT_MODE_RSVD_MASK;

    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (req.address)
            RUT_ADDR_MODE:   rdata_next[7:0] = mode_view;
            RUT_ADDR_COUNT:  rdata_next[7:0] = timer_count_value_reg;
            RUT_ADDR_CTRL:   rdata_next[1:0] = ctrl_reg;
            RUT_ADDR_STATUS: rdata_next[1:0] = {irq_mask_reg,
                                                timer_irq_flag_reg};
            default:         rdata_next = 32'h0000_0000;
        endcase
    end

    // one wait state: request taken, answered next cycle
    assign avs_waitrequest_o = access & ~ack_reg;
    assign avs_readdata_o    = rdata_reg;
    assign irq_o             = timer_irq_flag_reg & irq_mask_reg;

    // ------------------------------------------------------------
    // count next value
    // ------------------------------------------------------------
    always_comb begin
        timer_count_value_next = timer_count_value_reg;
        if (wr_reload && auto_reload) begin
            timer_count_value_next = req.writedata[7:0];
        end else if (wrap && auto_reload) begin
            timer_count_value_next = timer_reload_value_reg;
        end else if (step) begin
            // plain wrap follows from 8-bit arithmetic
            timer_count_value_next = count_down
                ? timer_count_value_reg - 8'h01
                : timer_count_value_reg + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_count_value_reg <= RUT_COUNT_RESET;
            event_prev_reg        <= 1'b0;
            ack_reg               <= 1'b0;
            rdata_reg             <= 32'h0000_0000;
        end else begin
            timer_count_value_reg <= timer_count_value_next;
            event_prev_reg        <= event_sync;
            ack_reg               <= access & ~ack_reg;
            if (req.read && !ack_reg) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_mode_select_reg  <= RUT_MODE_RESET;
            timer_reload_value_reg <= 8'h00;
            ctrl_reg               <= 2'h0;
            irq_mask_reg           <= 1'b0;
        end else begin
            if (wr_mode) begin
                timer_mode_select_reg <= req.writedata[7:0]
                                       & RUT_MODE_WR_MASK;
            end
            if (wr_reload) begin
                timer_reload_value_reg <= req.writedata[7:0];
            end
            if (wr_ctrl) begin
                ctrl_reg <= req.writedata[1:0];
            end
            if (wr_status) begin
                irq_mask_reg <= req.writedata[1];
            end
        end
    end

    // set wins over a same-cycle write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_irq_flag_reg <= 1'b0;
        end else if (wrap) begin
            timer_irq_flag_reg <= 1'b1;
        end else if (wr_status && req.writedata[0]) begin
            timer_irq_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_reset_zero;
        @(posedge clk_i) $fell(rst_i) |-> timer_count_value_reg == 8'h00;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("count not zero after reset");

    property p_rsvd_one;
        @(posedge clk_i) disable iff (rst_i)
        ack_reg && $past(req.read) && $past(req.address) == RUT_ADDR_MODE
        |-> avs_readdata_o[4:3] == 2'b11;
    endproperty
    a_rsvd_one: assert property (p_rsvd_one)
        else $error("reserved mode bits not read as one");

    property p_wrap_flag;
        @(posedge clk_i) disable iff (rst_i)
        wrap |=> timer_irq_flag_reg;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag)
        else $error("overflow did not set flag");

    property p_reload;
        @(posedge clk_i) disable iff (rst_i)
        wrap && auto_reload && !wr_reload
        |=> timer_count_value_reg == $past(timer_reload_value_reg);
    endproperty
    a_reload: assert property (p_reload)
        else $error("count not reloaded on wrap");

    property p_copy;
        @(posedge clk_i) disable iff (rst_i)
        wr_reload && auto_reload
        |=> timer_count_value_reg == $past(req.writedata[7:0]);
    endproperty
    a_copy: assert property (p_copy)
        else $error("reload write not copied to count");

    property p_free_wrap;
        @(posedge clk_i) disable iff (rst_i)
        wrap && !auto_reload && !count_down
        |=> timer_count_value_reg == 8'h00;
    endproperty
    a_free_wrap: assert property (p_free_wrap)
        else $error("free-running overflow did not wrap to zero");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        !step && !(wr_reload && auto_reload)
        |=> $stable(timer_count_value_reg);
    endproperty
    a_hold: assert property (p_hold)
        else $error("count moved without input clock");

    property p_hw_dir;
        @(posedge clk_i) disable iff (rst_i)
        step && !at_limit && timer_mode_select_reg[RUT_MODE_HWDIR_BIT]
        && dir_sync && !wr_reload
        |=> timer_count_value_reg == $past(timer_count_value_reg) - 8'h01;
    endproperty
    a_hw_dir: assert property (p_hw_dir)
        else $error("pin high did not count down");

    property p_wait;
        @(posedge clk_i) disable iff (rst_i)
        access && !ack_reg |=> !avs_waitrequest_o;
    endproperty
    a_wait: assert property (p_wait)
        else $error("bus answer late");

    property p_flag_clear;
        @(posedge clk_i) disable iff (rst_i)
        wr_status && req.writedata[0] && !wrap |=> !timer_irq_flag_reg;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("write one did not clear flag");

    property p_free_under;
        @(posedge clk_i) disable iff (rst_i)
        wrap && !auto_reload && count_down
        |=> timer_count_value_reg == RUT_COUNT_MAX;
    endproperty
    a_free_under: assert property (p_free_under)
        else $error("free-running underflow did not wrap to max");

    property p_sw_up;
        @(posedge clk_i) disable iff (rst_i)
        step && !at_limit && !timer_mode_select_reg[RUT_MODE_HWDIR_BIT]
        && !ctrl_reg[RUT_CTRL_SWDOWN_BIT] && !(wr_reload && auto_reload)
        |=> timer_count_value_reg == $past(timer_count_value_reg) + 8'h01;
    endproperty
    a_sw_up: assert property (p_sw_up)
        else $error("software direction low did not count up");

    property p_event_once;
        @(posedge clk_i) disable iff (rst_i)
        event_tick |=> !event_tick;
    endproperty
    a_event_once: assert property (p_event_once)
        else $error("one pin edge gave two steps");

    property p_reload_store;
        @(posedge clk_i) disable iff (rst_i)
        wr_reload |=> timer_reload_value_reg == $past(req.writedata[7:0]);
    endproperty
    a_reload_store: assert property (p_reload_store)
        else $error("reload value not stored");

    c_reload: cover property (@(posedge clk_i) wrap && auto_reload);
    c_event:  cover property (@(posedge clk_i)
                  event_tick && clock_select == RUT_CS_EVENT);
    c_down:   cover property (@(posedge clk_i) wrap && count_down);
    c_irq:    cover property (@(posedge clk_i) irq_o);
    c_free:   cover property (@(posedge clk_i) wrap && !auto_reload);
endmodule
